// file: ogli_port.sv
// eight-channel digital port with latching inputs and change interrupts
`include "ogli_consts.svh"

// Notes on behaviour
// - a configuration reset makes all channels inputs, outputs 1, no inversion or latching, pull-ups on, interrupts masked, push-pull.
// - an input read gives 0 for a low level and 1 for a high level.
// - an output channel still reads back the level at its terminal as input.
// - every input read touches the whole input register, so its side effects reach all channels.
// - a latched input that toggles and returns reads first the changed level, then the original one.
// - whole-port values are one byte with bit 0 for channel 0 and upward.
// - there are exactly eight channels, each with an output, input and status bit.
// - writing the output of an input channel stores the value without driving the pin.
// - reading the output register gives the stored bits, not the pin levels.
// - a status bit reads 1 while its channel raises an interrupt and 0 otherwise.
// - a non-latched change raises an interrupt, cleared by an input read or by the level returning.
// - a latched change captures the level and raises an interrupt that holds until an input read or a write of 1 to its status bit.
// - a direction bit of 0 makes the channel an output, 1 an input.
// - a mask bit of 0 allows the interrupt of its channel, 1 suppresses it.
module ogli_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire ogli_pkg::ogli_addr_t reg_addr,
  input wire ogli_pkg::ogli_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output ogli_pkg::ogli_byte_t rd_data,
  input wire ogli_pkg::ogli_byte_t pin_in,
  output ogli_pkg::ogli_byte_t pin_out,
  output ogli_pkg::ogli_byte_t pin_oe,
  output ogli_pkg::ogli_byte_t pull_up_en,
  output ogli_pkg::ogli_byte_t pull_dn_en,
  output logic irq
);
  import ogli_pkg::*;

  function automatic logic hit(input ogli_addr_t a, input ogli_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************
  // register decode
  // ****************************************
  ogli_byte_t out_q, dir_q, psel_q, pen_q, inv_q, lat_q, mask_q;
  logic od_q;
  ogli_byte_t status, held, latch_q, ref_lvl;
  ogli_byte_t sync1, sync2, sync3, filt;

  wire rd_in = clk_en & rd_en & hit(reg_addr, `OGLI_OFS_INPUT);
  wire wr_ok = clk_en & wr_en;
  wire w_out = wr_ok & hit(reg_addr, `OGLI_OFS_OUTPUT);
  wire w_dir = wr_ok & hit(reg_addr, `OGLI_OFS_DIR);
  wire w_psel = wr_ok & hit(reg_addr, `OGLI_OFS_PULL_SEL);
  wire w_pen = wr_ok & hit(reg_addr, `OGLI_OFS_PULL_EN);
  wire w_inv = wr_ok & hit(reg_addr, `OGLI_OFS_INVERT);
  wire w_lat = wr_ok & hit(reg_addr, `OGLI_OFS_LATCH);
  wire w_mask = wr_ok & hit(reg_addr, `OGLI_OFS_MASK);
  wire w_od = wr_ok & hit(reg_addr, `OGLI_OFS_OUT_TYPE);
  wire w_stat = wr_ok & hit(reg_addr, `OGLI_OFS_STATUS);
  wire cfg_rst = wr_ok & hit(reg_addr, `OGLI_OFS_CTRL) & wr_data[`OGLI_BIT_CFG_RESET];

  // ****************************************
  // input path
  // ****************************************
  // inversion first, so change detection and latching see the software view
  wire ogli_byte_t lvl = filt ^ inv_q;
  wire ogli_byte_t diff = lvl ^ ref_lvl;
  wire ogli_byte_t cap = lat_q & ~held & diff;
  // non-latched bits show the live level, latched bits the captured one
  wire ogli_byte_t in_val = (lat_q & latch_q) | (~lat_q & lvl);
  wire ogli_byte_t set_irq = ~mask_q & ((lat_q & cap) | (~lat_q & diff));
  // a read clears all channels at once, whichever one software wanted
  wire ogli_byte_t clr_irq = (rd_in ? 8'hFF : 8'h00) | (w_stat ? wr_data : 8'h00)
                           | (~lat_q & ~diff);
  wire ogli_byte_t next_status = set_irq | (status & ~clr_irq);
  wire ogli_byte_t next_held = cap | (held & ~(rd_in ? 8'hFF : 8'h00));
  wire ogli_byte_t next_latch = (cap | ~lat_q) & lvl | ~(cap | ~lat_q) & latch_q;
  // after a read the reference is what was returned; a reverted latched bit then fires again
  wire ogli_byte_t next_ref = rd_in ? in_val : ref_lvl;

  // ****************************************
  // read mux
  // ****************************************
  wire ogli_byte_t rd_mux =
    hit(reg_addr, `OGLI_OFS_INPUT) ? in_val :
    hit(reg_addr, `OGLI_OFS_OUTPUT) ? out_q :
    hit(reg_addr, `OGLI_OFS_DIR) ? dir_q :
    hit(reg_addr, `OGLI_OFS_PULL_SEL) ? psel_q :
    hit(reg_addr, `OGLI_OFS_PULL_EN) ? pen_q :
    hit(reg_addr, `OGLI_OFS_INVERT) ? inv_q :
    hit(reg_addr, `OGLI_OFS_LATCH) ? lat_q :
    hit(reg_addr, `OGLI_OFS_MASK) ? mask_q :
    hit(reg_addr, `OGLI_OFS_OUT_TYPE) ? {7'h00, od_q} :
    hit(reg_addr, `OGLI_OFS_STATUS) ? status : 8'h00;

  // ****************************************
  // pin drive
  // ****************************************
  // open-drain only ever pulls low, and its pull resistor is switched off
  wire ogli_byte_t next_oe = ~dir_q & (od_q ? ~out_q : 8'hFF);
  wire ogli_byte_t next_pout = od_q ? 8'h00 : out_q;
  wire ogli_byte_t pull_ok = pen_q & ~(od_q ? ~dir_q : 8'h00);

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst || cfg_rst)
    begin
      out_q <= `OGLI_RST_OUTPUT;
      dir_q <= `OGLI_RST_DIR;
      psel_q <= `OGLI_RST_PULL_SEL;
      pen_q <= `OGLI_RST_PULL_EN;
      inv_q <= `OGLI_RST_INVERT;
      lat_q <= `OGLI_RST_LATCH;
      mask_q <= `OGLI_RST_MASK;
      od_q <= `OGLI_RST_OUT_TYPE;
    end
    else if (clk_en)
    begin
      if (w_out) out_q <= wr_data;
      if (w_dir) dir_q <= wr_data;
      if (w_psel) psel_q <= wr_data;
      if (w_pen) pen_q <= wr_data;
      if (w_inv) inv_q <= wr_data;
      if (w_lat) lat_q <= wr_data;
      if (w_mask) mask_q <= wr_data;
      if (w_od) od_q <= wr_data[`OGLI_BIT_OPEN_DRAIN];
    end
  end

  // ****************************************
  // input sampling: three flops, change taken once the last two agree
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) filt[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // latch, status and interrupt
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status <= 8'h00;
      held <= 8'h00;
      latch_q <= 8'h00;
      ref_lvl <= 8'h00;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      status <= cfg_rst ? 8'h00 : next_status;
      held <= cfg_rst ? 8'h00 : next_held;
      latch_q <= next_latch;
      ref_lvl <= next_ref;
      irq <= cfg_rst ? 1'b0 : |next_status;
    end
  end

  // ****************************************
  // bus answer and pin outputs
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data <= 8'h00;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pull_up_en <= 8'h00;
      pull_dn_en <= 8'h00;
    end
    else if (clk_en)
    begin
      rd_data <= rd_en ? rd_mux : 8'h00;
      pin_out <= next_pout;
      pin_oe <= next_oe;
      pull_up_en <= pull_ok & psel_q;
      pull_dn_en <= pull_ok & ~psel_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_reset_cfg;
    $past(sys_rst) |-> dir_q == 8'hFF && out_q == 8'hFF && inv_q == 8'h00 && lat_q == 8'h00
      && pen_q == 8'hFF && psel_q == 8'hFF && mask_q == 8'hFF && !od_q;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("config not at defaults after reset");

  property p_in_no_drive;
    $past(clk_en) |-> (pin_oe & $past(dir_q)) == 8'h00;
  endproperty
  a_in_no_drive: assert property (p_in_no_drive) else $error("input channel drives its pin");

  property p_out_read;
    clk_en && rd_en && reg_addr == `OGLI_OFS_OUTPUT |=> rd_data == $past(out_q);
  endproperty
  a_out_read: assert property (p_out_read) else $error("output read not stored value");

  property p_in_read_live;
    rd_in && lat_q == 8'h00 |=> rd_data == $past(filt ^ inv_q);
  endproperty
  a_in_read_live: assert property (p_in_read_live) else $error("input read not pin level");

  property p_read_clears;
    rd_in && lat_q == 8'h00 && lvl == ref_lvl |=> status == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("input read left status set");

  property p_latched_hold;
    clk_en && !wr_en && !rd_in |=> (status & $past(status & lat_q)) == $past(status & lat_q);
  endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched status lost before read");

  property p_irq_any;
    irq == (status != 8'h00);
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("irq disagrees with status");

  property p_mask_blocks;
    clk_en |=> (status & ~$past(status) & $past(mask_q)) == 8'h00;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked channel raised status");

  property p_rd_one_cycle;
    !rd_en || !clk_en |=> rd_data == 8'h00 || !$past(clk_en);
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read data outside answer cycle");

  // ****************************************
  // pin drive, pull and status assertions
  // ****************************************
  property p_oe_follows_dir;
    clk_en && !od_q |=> pin_oe == ~$past(dir_q);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("push-pull enable not from direction");

  property p_pp_value;
    clk_en && !od_q |=> pin_out == $past(out_q);
  endproperty
  a_pp_value: assert property (p_pp_value) else $error("push-pull drive not stored value");

  property p_od_low;
    clk_en && od_q |=> pin_out == 8'h00 && pin_oe == $past(~dir_q & ~out_q);
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain drive wrong");

  property p_od_no_pull;
    clk_en && od_q |=> ((pull_up_en | pull_dn_en) & ~$past(dir_q)) == 8'h00;
  endproperty
  a_od_no_pull: assert property (p_od_no_pull) else $error("pull left on open-drain output");

  property p_pull_exclusive;
    (pull_up_en & pull_dn_en) == 8'h00;
  endproperty
  a_pull_exclusive: assert property (p_pull_exclusive) else $error("pull-up and pull-down together");

  property p_pull_up_sel;
    clk_en && !od_q |=> pull_up_en == $past(pen_q & psel_q);
  endproperty
  a_pull_up_sel: assert property (p_pull_up_sel) else $error("pull-up enable wrong");

  property p_cfg_reset;
    cfg_rst |=> dir_q == `OGLI_RST_DIR && out_q == `OGLI_RST_OUTPUT && mask_q == `OGLI_RST_MASK
      && lat_q == `OGLI_RST_LATCH && !od_q && status == 8'h00 && !irq;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset left state");

  property p_status_w1c;
    w_stat |=> (status & $past(wr_data & ~set_irq)) == 8'h00;
  endproperty
  a_status_w1c: assert property (p_status_w1c) else $error("status bit not cleared by write");

  property p_status_read;
    clk_en && rd_en && reg_addr == `OGLI_OFS_STATUS |=> rd_data == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_nonlatch_return;
    clk_en |=> (status & ~$past(lat_q) & ~$past(lvl ^ ref_lvl)) == 8'h00;
  endproperty
  a_nonlatch_return: assert property (p_nonlatch_return) else $error("non-latched status without change");

  property p_latch_capture;
    clk_en |=> (latch_q & $past(cap)) == ($past(lvl) & $past(cap));
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("changed level not captured");

  property p_read_clear_all;
    rd_in |=> (status & ~$past(set_irq)) == 8'h00;
  endproperty
  a_read_clear_all: assert property (p_read_clear_all) else $error("input read left a channel set");

  property p_ref_after_read;
    rd_in |=> ref_lvl == rd_data;
  endproperty
  a_ref_after_read: assert property (p_ref_after_read) else $error("reference not the returned value");

  // a level still settling in the synchroniser must not reach the logic
  property p_sync_filter;
    clk_en && sync2 != sync3 |=> filt == $past(filt);
  endproperty
  a_sync_filter: assert property (p_sync_filter) else $error("unsettled level taken");

  property p_freeze;
    !clk_en |=> status == $past(status) && dir_q == $past(dir_q) && rd_data == $past(rd_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
endmodule : ogli_port

// file: ogli_consts.svh
// register offsets, reset values and field positions of the octal port
`ifndef OGLI_CONSTS_SVH
`define OGLI_CONSTS_SVH
`define OGLI_OFS_INPUT 4'h0
`define OGLI_OFS_OUTPUT 4'h1
`define OGLI_OFS_DIR 4'h2
`define OGLI_OFS_PULL_SEL 4'h3
`define OGLI_OFS_PULL_EN 4'h4
`define OGLI_OFS_INVERT 4'h5
`define OGLI_OFS_LATCH 4'h6
`define OGLI_OFS_MASK 4'h7
`define OGLI_OFS_OUT_TYPE 4'h8
`define OGLI_OFS_STATUS 4'h9
`define OGLI_OFS_CTRL 4'hA
`define OGLI_RST_OUTPUT 8'hFF
`define OGLI_RST_DIR 8'hFF
`define OGLI_RST_PULL_SEL 8'hFF
`define OGLI_RST_PULL_EN 8'hFF
`define OGLI_RST_INVERT 8'h00
`define OGLI_RST_LATCH 8'h00
`define OGLI_RST_MASK 8'hFF
`define OGLI_RST_OUT_TYPE 1'h0
`define OGLI_BIT_OPEN_DRAIN 0
`define OGLI_BIT_CFG_RESET 0
`endif

// file: ogli_pkg.sv
// types shared by the octal port
package ogli_pkg;
  typedef logic [7:0] ogli_byte_t;
  typedef logic [3:0] ogli_addr_t;
endpackage : ogli_pkg

// file: ogli_far_end.sv
// terminal model of the octal port: external drivers resolved against the port's own drive
module ogli_far_end (
  input wire ogli_pkg::ogli_byte_t ext_level,
  input wire ogli_pkg::ogli_byte_t pin_out,
  input wire ogli_pkg::ogli_byte_t pin_oe,
  output ogli_pkg::ogli_byte_t pin_in
);
  import ogli_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // a driven channel shows its own output level, an undriven one the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : ogli_far_end

// file: tb_top.sv
// self-checking bench of the octal port
`include "ogli_consts.svh"
module tb_top;
  import ogli_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, wr_en, rd_en;
  ogli_addr_t reg_addr;
  ogli_byte_t wr_data, rd_data, pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, ext, seed, r;
  logic irq;
  int error_cnt, comparisons, cyc, i;
  ogli_port i_ogli_port (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .irq(irq));
  ogli_far_end i_ogli_far_end (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  // ****************************************
  // helpers
  // ****************************************
  function automatic ogli_byte_t lfsr(input ogli_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic ogli_byte_t exp_in(input ogli_byte_t lvl, input ogli_byte_t inv);
    return lvl ^ inv;
  endfunction : exp_in
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic wr(input ogli_addr_t a, input ogli_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input ogli_addr_t a, input ogli_byte_t exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp, what);
  endtask : rd
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ****************************************
  // clock, reset and watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang in any wait ends the run well after the sequence needs about 210 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    sys_rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; reg_addr = 4'h0; wr_data = 8'h00;
    ext = 8'h00; seed = 8'h38; cyc = 0; error_cnt = 0; comparisons = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    w(3);
    chk(pull_up_en, 8'hFF, "pull-ups after reset");
    chk(pin_oe, 8'h00, "all inputs after reset");
    $display("test reset done");
    // masked change leaves irq low, then unmasked changes raise it
    seed = lfsr(seed);
    ext = seed | 8'h01;
    w(6);
    chk({7'h00, irq}, 8'h00, "masked change");
    wr(`OGLI_OFS_MASK, 8'h00);
    rd(`OGLI_OFS_INPUT, ext, "input level");
    ext = 8'h00;
    w(6);
    chk({7'h00, irq}, 8'h01, "irq on change");
    rd(`OGLI_OFS_STATUS, seed | 8'h01, "status bits per channel");
    rd(`OGLI_OFS_INPUT, 8'h00, "input after change");
    w(2);
    chk({7'h00, irq}, 8'h00, "irq cleared by input read");
    ext = 8'h80;
    w(6);
    chk({7'h00, irq}, 8'h01, "irq on channel 7");
    ext = 8'h00;
    w(6);
    chk({7'h00, irq}, 8'h00, "return to level clears");
    $display("test change interrupt done");
    wr(`OGLI_OFS_LATCH, 8'hFF);
    ext = 8'h0F;
    w(6);
    ext = 8'h00;
    w(6);
    chk({7'h00, irq}, 8'h01, "latched irq holds");
    rd(`OGLI_OFS_INPUT, 8'h0F, "latched changed level");
    rd(`OGLI_OFS_INPUT, 8'h00, "latched original level");
    w(2);
    chk({7'h00, irq}, 8'h00, "whole register cleared");
    $display("test latch done");
    wr(`OGLI_OFS_LATCH, 8'h00);
    seed = lfsr(seed);
    wr(`OGLI_OFS_INVERT, seed);
    w(6);
    rd(`OGLI_OFS_INPUT, exp_in(ext, seed), "inverted input");
    wr(`OGLI_OFS_INVERT, 8'h00);
    $display("test invert done");
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      r = (i == 0) ? 8'h00 : seed;
      wr(`OGLI_OFS_DIR, 8'hFF);
      wr(`OGLI_OFS_OUTPUT, r);
      w(2);
      chk(pin_oe, 8'h00, "stored without drive");
      rd(`OGLI_OFS_OUTPUT, r, "output register");
      wr(`OGLI_OFS_DIR, 8'h00);
      w(2);
      chk(pin_oe, 8'hFF, "direction 0 drives");
      chk(pin_out, r, "driven value");
      w(4);
      rd(`OGLI_OFS_INPUT, r, "terminal level of outputs");
    end
    $display("test output done");
    // open-drain drives zeros only and drops the pulls of its output channels
    wr(`OGLI_OFS_OUT_TYPE, 8'h01);
    wr(`OGLI_OFS_OUTPUT, 8'h0F);
    w(2);
    chk(pin_oe, 8'hF0, "open-drain drives zeros only");
    chk(pin_out, 8'h00, "open-drain low level");
    chk(pull_up_en, 8'h00, "pulls off on open-drain outputs");
    wr(`OGLI_OFS_DIR, 8'hFF);
    wr(`OGLI_OFS_PULL_SEL, 8'h00);
    w(2);
    chk(pull_dn_en, 8'hFF, "pull-downs on inputs");
    chk(pull_up_en, 8'h00, "pull-ups deselected");
    w(4);
    rd(`OGLI_OFS_INPUT, ext, "released terminals");
    // one status bit is cleared alone by writing a one, the other by an input read
    wr(`OGLI_OFS_LATCH, 8'hFF);
    ext = 8'h24;
    w(6);
    rd(`OGLI_OFS_STATUS, 8'h24, "latched status");
    wr(`OGLI_OFS_STATUS, 8'h04);
    rd(`OGLI_OFS_STATUS, 8'h20, "status after write one to clear");
    rd(`OGLI_OFS_INPUT, 8'h24, "latched level");
    w(2);
    chk({7'h00, irq}, 8'h00, "irq low after read");
    wr(`OGLI_OFS_LATCH, 8'h00);
    $display("test open-drain and status done");
    wr(4'hB, 8'h5A);
    rd(4'hB, 8'h00, "unmapped read");
    wr(`OGLI_OFS_CTRL, 8'h01);
    rd(`OGLI_OFS_OUTPUT, `OGLI_RST_OUTPUT, "output default");
    rd(`OGLI_OFS_DIR, `OGLI_RST_DIR, "direction default");
    rd(`OGLI_OFS_INVERT, `OGLI_RST_INVERT, "invert default");
    rd(`OGLI_OFS_LATCH, `OGLI_RST_LATCH, "latch default");
    rd(`OGLI_OFS_MASK, `OGLI_RST_MASK, "mask default");
    rd(`OGLI_OFS_OUT_TYPE, 8'h00, "push-pull default");
    chk(pull_up_en, 8'hFF, "pull-ups after config reset");
    chk(pin_oe, 8'h00, "inputs after config reset");
    $display("test config reset done");
    close_out();
  end
endmodule : tb_top
